/* bench/ct_monitor.sv */
// checker watching the counter timer ports
`timescale 1ns/1ps
`default_nettype none
`include "counter_timer_consts.vh"
module ct_monitor (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// counter side
	input wire logic counter_zero_pulse_i,
	input wire logic pin_routing_select_i,
	input wire logic [3:0] pin_oe_o,
	input wire logic [23:0] counter_zero_value_o,
	input wire logic [15:0] counter_one_value_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	// clear commands for each counter
	sequence zero0_s;
		reg_wr_i && reg_addr_i == 4'hf && reg_wdata_i == 8'h01;
	endsequence
	sequence zero1_s;
		reg_wr_i && reg_addr_i == 4'hf && reg_wdata_i == 8'h81;
	endsequence
	clear_zero_a: assert property (
		zero0_s |-> ##2 counter_zero_value_o == 24'h0)
		else $error("counter zero not cleared");
	clear_one_a: assert property (
		zero1_s |-> ##2 counter_one_value_o == 16'h0)
		else $error("counter one not cleared");
	read_idle_a: assert property (
		!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	ident_read_a: assert property (
		reg_rd_i && reg_addr_i == 4'hf
		|=> reg_rdata_o == {`CT_BOARD_ID, `CT_LOGIC_REV})
		else $error("identity read wrong");
	hold_zero_a: assert property (
		!counter_zero_pulse_i && !reg_wr_i
		|-> ##2 $stable(counter_zero_value_o))
		else $error("counter zero moved without cause");
	step_zero_a: assert property (
		!reg_wr_i |-> ##2 (counter_zero_value_o == $past(counter_zero_value_o)
		|| counter_zero_value_o == $past(counter_zero_value_o) - 24'h1))
		else $error("counter zero stepped wrongly");
	step_one_a: assert property (
		!reg_wr_i |-> ##2 (counter_one_value_o == $past(counter_one_value_o)
		|| counter_one_value_o == $past(counter_one_value_o) - 16'h1))
		else $error("counter one stepped wrongly");
	route_oe_a: assert property (
		pin_routing_select_i |=> pin_oe_o == 4'h8)
		else $error("routed pin enables wrong");
endmodule
`default_nettype wire

/* bench/pulse_gate_source.sv */
// model of the external pulse and gate sources
`timescale 1ns/1ps
`default_nettype none
module pulse_gate_source (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// burst request
	input wire logic start_i,
	input wire logic slow_i,
	input wire logic [7:0] count_i,
	input wire logic [1:0] gate_i,
	// lines toward the counters
	output logic pulse_o,
	output logic [1:0] gate_o,
	output logic busy_o
);
	logic [7:0] left_q;
	logic gap_q;
	assign busy_o = (left_q != 8'h00) | pulse_o;
	// one high cycle per count, a gap between counts when slow
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			left_q <= 8'h00;
			gap_q <= 1'b0;
			pulse_o <= 1'b0;
			gate_o <= 2'h0;
		end else begin
			gate_o <= gate_i;
			gap_q <= slow_i & ~gap_q;
			pulse_o <= 1'b0;
			if (start_i) begin
				left_q <= count_i;
			end else if (left_q != 8'h00 && !gap_q) begin
				pulse_o <= 1'b1;
				left_q <= left_q - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/tb.sv */
// testbench for the dual down-counter timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst = 1, wr = 0, rd = 0, st = 0, slow = 0, route = 1;
	logic [3:0] a = 0, poe;
	logic [7:0] wd = 0, n = 0, rdat;
	logic [1:0] g = 0, go;
	logic p, busy, zout;
	logic [3:0] pout, din;
	int n_errors = 0, total_checks = 0;
	// free-running clock
	always #5 clk = ~clk;
	dual_down_counter_timer i_dual_down_counter_timer (.core_clk_i(clk),
		.reset_i(rst), .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdat), .counter_zero_pulse_i(p),
		.counter_one_pulse_in_i(p), .pin_routing_select_i(route),
		.counter_zero_gate_in_i(go[0]), .counter_one_gate_in_i(go[1]),
		.counter_one_pin_pulse_i(p), .dio_in_o(din), .dio_out_i(4'h0),
		.dio_oe_i(4'h5), .pin_out_o(pout), .pin_oe_o(poe),
		.counter_zero_value_o(), .counter_one_value_o(),
		.counter_zero_out_o(zout));
	pulse_gate_source i_pulse_gate_source (.core_clk_i(clk), .reset_i(rst),
		.start_i(st), .slow_i(slow), .count_i(n), .gate_i(g), .pulse_o(p),
		.gate_o(go), .busy_o(busy));
	task print_verdict;
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input [23:0] got, input [23:0] e);
		total_checks++;
		if (got !== e) begin
			n_errors++;
			$display("mismatch %0t got %h exp %h", $time, got, e);
		end
	endtask
	task w(input [3:0] ad, input [7:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task r(input [3:0] ad, input [7:0] e);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk({16'h0, rdat}, {16'h0, e});
	endtask
	// latch a counter and read back its snapshot bytes
	task snap(input [7:0] c, input [23:0] e);
		w(4'hf, c);
		r(4'hc, e[7:0]);
		r(4'hd, e[15:8]);
		if (!c[7]) r(4'he, e[23:16]);
	endtask
	// pulse burst from the partner, wait bounded for its end
	task run(input [7:0] k, input [1:0] gl, input s);
		int i;
		@(posedge clk);
		n <= k;
		g <= gl;
		slow <= s;
		st <= 1;
		@(posedge clk);
		st <= 0;
		#1;
		for (i = 0; i < 300 && busy; i++) begin
			@(posedge clk);
			#1;
		end
		if (busy !== 1'b0) begin
			n_errors++;
			print_verdict;
		end
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		r(4'hc, 8'h00);
		r(4'he, 8'h00);
		r(4'hf, 8'h31);
		r(4'h0, 8'h00);
		w(4'hc, 8'h11);
		w(4'hd, 8'h22);
		w(4'he, 8'h33);
		r(4'hc, 8'h00);
		w(4'hf, 8'h02);
		snap(8'h40, 24'h332211);
		w(4'hf, 8'h82);
		snap(8'hc0, 24'h2211);
		r(4'he, 8'h33);
		w(4'hf, 8'h04);
		run(5, 0, 0);
		snap(8'h40, 24'h33220c);
		snap(8'hc0, 24'h2211);
		w(4'hf, 8'h0c);
		run(3, 0, 0);
		snap(8'h7f, 24'h33220c);
		w(4'hf, 8'h14);
		run(2, 3, 0);
		snap(8'h40, 24'h33220c);
		w(4'hf, 8'h04);
		run(4, 0, 1);
		snap(8'h40, 24'h33220c);
		run(2, 3, 1);
		snap(8'h40, 24'h33220a);
		chk({20'h0, din}, 24'h3);
		w(4'hf, 8'h20);
		run(1, 0, 0);
		snap(8'h40, 24'h332209);
		w(4'hf, 8'h01);
		repeat (2) @(posedge clk);
		#1 chk({23'h0, zout}, 24'h1);
		chk({20'h0, pout}, 24'h8);
		run(1, 0, 0);
		snap(8'h40, 24'hffffff);
		chk({20'h0, poe}, 24'h8);
		chk({23'h0, zout}, 24'h0);
		w(4'hf, 8'h84);
		@(posedge clk) route <= 0;
		run(2, 0, 0);
		snap(8'hc0, 24'h220f);
		snap(8'h40, 24'hfffffd);
		chk({20'h0, poe}, 24'h5);
		w(4'hf, 8'h81);
		snap(8'hc0, 24'h0);
		print_verdict;
	end
endmodule
bind dual_down_counter_timer ct_monitor i_ct_monitor (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .counter_zero_pulse_i(counter_zero_pulse_i),
	.pin_routing_select_i(pin_routing_select_i), .pin_oe_o(pin_oe_o),
	.counter_zero_value_o(counter_zero_value_o),
	.counter_one_value_o(counter_one_value_o));
`default_nettype wire

/* logic/dual_down_counter_timer.v */
// dual down-counter timer: 24-bit and 16-bit counters with byte registers
//
// Overview of operation
// - low byte write fills shared holding register only
// - mid holding byte loads bits 15..8
// - counter zero 24 bits, counter one 16
// - high holding byte loads counter zero only
// - data reads return latched snapshot bytes
// - counter one latch keeps high snapshot byte
// - command bit seven selects target counter
// - highest set command bit of 6..0 wins alone
// - command changes only its own setting
// - latch copies count into snapshot bytes
// - gating on: count only while gate high
// - gating off: gate input ignored
// - counting on: decrement per input pulse
// - counting off: input pulses ignored
// - load copies holding bytes into counter
// - zero clears count, enables kept
// - command offset read gives identity, revision
// - routing select one maps counter pins
`timescale 1ns/1ps
`default_nettype none
`include "counter_timer_consts.vh"

module dual_down_counter_timer (
	// clock and reset
	input wire core_clk_i,
	input wire reset_i,
	// register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// counter pulse inputs, one cycle high per pulse
	input wire counter_zero_pulse_i,
	input wire counter_one_pulse_in_i,
	// shared pins: routing select and raw pin levels
	input wire pin_routing_select_i,
	input wire counter_zero_gate_in_i,
	input wire counter_one_gate_in_i,
	input wire counter_one_pin_pulse_i,
	// digital port lines when pins are not routed to counters
	output reg [3:0] dio_in_o,
	input wire [3:0] dio_out_i,
	input wire [3:0] dio_oe_i,
	// pin drive toward shared pins
	output reg [3:0] pin_out_o,
	output reg [3:0] pin_oe_o,
	// counter state visible outside
	output reg [23:0] counter_zero_value_o,
	output reg [15:0] counter_one_value_o,
	output reg counter_zero_out_o
);

	// highest set bit of 6..0 picks the single operation
	function [2:0] decode_op;
		input [7:0] cmd;
		begin
			if (cmd[`CT_CMD_LATCH])
				decode_op = `CT_OP_LATCH;
			else if (cmd[`CT_CMD_GATE_OFF])
				decode_op = `CT_OP_GATE_OFF;
			else if (cmd[`CT_CMD_GATE_ON])
				decode_op = `CT_OP_GATE_ON;
			else if (cmd[`CT_CMD_COUNT_OFF])
				decode_op = `CT_OP_COUNT_OFF;
			else if (cmd[`CT_CMD_COUNT_ON])
				decode_op = `CT_OP_COUNT_ON;
			else if (cmd[`CT_CMD_LOAD])
				decode_op = `CT_OP_LOAD;
			else if (cmd[`CT_CMD_ZERO])
				decode_op = `CT_OP_ZERO;
			else
				decode_op = `CT_OP_NONE;
		end
	endfunction

	// true when a command write aims this operation at this counter
	function cmd_hits;
		input wr;
		input sel;
		input want_sel;
		input [2:0] cmd_op;
		input [2:0] want_op;
		begin
			cmd_hits = wr && (sel == want_sel) && (cmd_op == want_op);
		end
	endfunction

	// a pulse counts only if enabled and the gate, when used, is high
	function step_ok;
		input pulse;
		input count_en;
		input gate_en;
		input gate;
		begin
			step_ok = pulse && count_en && (!gate_en || gate);
		end
	endfunction

	// terminal count of counter zero, shown on its output pin
	function c0_is_zero;
		input [23:0] value;
		begin
			c0_is_zero = (value == `CT_C0_RST);
		end
	endfunction

	// holding bytes written by software
	reg [7:0] hold_low_q;
	reg [7:0] hold_low_d;
	reg [7:0] hold_mid_q;
	reg [7:0] hold_mid_d;
	reg [7:0] hold_high_q;
	reg [7:0] hold_high_d;
	// snapshot bytes returned on data reads
	reg [7:0] snap_low_q;
	reg [7:0] snap_low_d;
	reg [7:0] snap_mid_q;
	reg [7:0] snap_mid_d;
	reg [7:0] snap_high_q;
	reg [7:0] snap_high_d;
	// counts and their enables
	reg [23:0] count0_q;
	reg [23:0] count0_d;
	reg [15:0] count1_q;
	reg [15:0] count1_d;
	reg count_en0_q;
	reg count_en0_d;
	reg count_en1_q;
	reg count_en1_d;
	reg gate_en0_q;
	reg gate_en0_d;
	reg gate_en1_q;
	reg gate_en1_d;
	// next values of the registered outputs
	reg [7:0] rdata_d;
	reg [3:0] dio_in_d;
	reg [3:0] pin_out_d;
	reg [3:0] pin_oe_d;
	reg c0_out_d;
	// decoded command strobes and qualified steps
	wire cmd_wr;
	wire [2:0] op;
	wire sel1;
	wire load0;
	wire load1;
	wire zero0;
	wire zero1;
	wire latch0;
	wire latch1;
	wire counter_zero_gate_in;
	wire counter_one_gate_in;
	wire pulse1;
	wire step0;
	wire step1;

	// command decode: target counter and single operation
	assign cmd_wr = reg_wr_i && (reg_addr_i == `CT_OFS_CMD);
	assign op = decode_op(reg_wdata_i);
	assign sel1 = reg_wdata_i[`CT_CMD_SEL];

	// one strobe per counter and operation, never two at once
	assign load0 = cmd_hits(cmd_wr, sel1, 1'b0, op, `CT_OP_LOAD);
	assign load1 = cmd_hits(cmd_wr, sel1, 1'b1, op, `CT_OP_LOAD);
	assign zero0 = cmd_hits(cmd_wr, sel1, 1'b0, op, `CT_OP_ZERO);
	assign zero1 = cmd_hits(cmd_wr, sel1, 1'b1, op, `CT_OP_ZERO);
	assign latch0 = cmd_hits(cmd_wr, sel1, 1'b0, op, `CT_OP_LATCH);
	assign latch1 = cmd_hits(cmd_wr, sel1, 1'b1, op, `CT_OP_LATCH);

	// gate pins feed counters only when routed, else gates read low; counter one takes its pin pulse when routed, else its pulse input
	assign counter_zero_gate_in = pin_routing_select_i & counter_zero_gate_in_i;
	assign counter_one_gate_in = pin_routing_select_i & counter_one_gate_in_i;
	assign pulse1 = pin_routing_select_i ? counter_one_pin_pulse_i :
		counter_one_pulse_in_i;

	// decrement qualified by count enable and optional gate
	assign step0 = step_ok(counter_zero_pulse_i, count_en0_q, gate_en0_q,
		counter_zero_gate_in);
	assign step1 = step_ok(pulse1, count_en1_q, gate_en1_q,
		counter_one_gate_in);

	// holding registers take data writes only
	always @* begin
		hold_low_d = hold_low_q;
		hold_mid_d = hold_mid_q;
		hold_high_d = hold_high_q;
		if (reg_wr_i) begin
			if (reg_addr_i == `CT_OFS_LOW)
				hold_low_d = reg_wdata_i;
			if (reg_addr_i == `CT_OFS_MID)
				hold_mid_d = reg_wdata_i;
			if (reg_addr_i == `CT_OFS_HIGH)
				hold_high_d = reg_wdata_i;
		end
	end

	// holding byte flops
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hold_low_q <= `CT_BYTE_RST;
			hold_mid_q <= `CT_BYTE_RST;
			hold_high_q <= `CT_BYTE_RST;
		end else begin
			hold_low_q <= hold_low_d;
			hold_mid_q <= hold_mid_d;
			hold_high_q <= hold_high_d;
		end
	end

	// enables: each command touches one flag of one counter only
	always @* begin
		count_en0_d = count_en0_q;
		count_en1_d = count_en1_q;
		gate_en0_d = gate_en0_q;
		gate_en1_d = gate_en1_q;
		if (cmd_wr) begin
			case (op)
				`CT_OP_GATE_OFF: begin
					if (sel1)
						gate_en1_d = 1'b0;
					else
						gate_en0_d = 1'b0;
				end
				`CT_OP_GATE_ON: begin
					if (sel1)
						gate_en1_d = 1'b1;
					else
						gate_en0_d = 1'b1;
				end
				`CT_OP_COUNT_OFF: begin
					if (sel1)
						count_en1_d = 1'b0;
					else
						count_en0_d = 1'b0;
				end
				`CT_OP_COUNT_ON: begin
					if (sel1)
						count_en1_d = 1'b1;
					else
						count_en0_d = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// enable flops, all off after reset
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_en0_q <= 1'b0;
			count_en1_q <= 1'b0;
			gate_en0_q <= 1'b0;
			gate_en1_q <= 1'b0;
		end else begin
			count_en0_q <= count_en0_d;
			count_en1_q <= count_en1_d;
			gate_en0_q <= gate_en0_d;
			gate_en1_q <= gate_en1_d;
		end
	end

	// counter zero: load or clear beat a pulse in the same cycle
	always @* begin
		count0_d = count0_q;
		if (load0)
			count0_d = {hold_high_q, hold_mid_q, hold_low_q};
		else if (zero0)
			count0_d = `CT_C0_RST;
		else if (step0)
			count0_d = count0_q - `CT_C0_STEP;
	end

	// counter one: high holding byte unused
	always @* begin
		count1_d = count1_q;
		if (load1)
			count1_d = {hold_mid_q, hold_low_q};
		else if (zero1)
			count1_d = `CT_C1_RST;
		else if (step1)
			count1_d = count1_q - `CT_C1_STEP;
	end

	// count flops, wrap from zero comes from the subtraction
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count0_q <= `CT_C0_RST;
			count1_q <= `CT_C1_RST;
		end else begin
			count0_q <= count0_d;
			count1_q <= count1_d;
		end
	end

	// snapshot bytes captured by latch command
	always @* begin
		snap_low_d = snap_low_q;
		snap_mid_d = snap_mid_q;
		snap_high_d = snap_high_q;
		if (latch0) begin
			snap_low_d = count0_q[7:0];
			snap_mid_d = count0_q[15:8];
			snap_high_d = count0_q[23:16];
		end else if (latch1) begin
			snap_low_d = count1_q[7:0];
			snap_mid_d = count1_q[15:8];
		end
	end

	// snapshot flops
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			snap_low_q <= `CT_BYTE_RST;
			snap_mid_q <= `CT_BYTE_RST;
			snap_high_q <= `CT_BYTE_RST;
		end else begin
			snap_low_q <= snap_low_d;
			snap_mid_q <= snap_mid_d;
			snap_high_q <= snap_high_d;
		end
	end

	// read data one cycle after strobe, zero otherwise
	always @* begin
		rdata_d = `CT_BYTE_RST;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`CT_OFS_LOW: rdata_d = snap_low_q;
				`CT_OFS_MID: rdata_d = snap_mid_q;
				`CT_OFS_HIGH: rdata_d = snap_high_q;
				`CT_OFS_CMD: rdata_d = {`CT_BOARD_ID, `CT_LOGIC_REV};
				default: rdata_d = `CT_BYTE_RST;
			endcase
		end
	end

	// pin routing: bits 0..2 inputs for counters, bit 3 counter output
	always @* begin
		dio_in_d = {`CT_DIO_SPARE, counter_one_pin_pulse_i,
			counter_one_gate_in_i, counter_zero_gate_in_i};
		c0_out_d = c0_is_zero(count0_q);
		if (pin_routing_select_i) begin
			pin_out_d = {c0_is_zero(count0_q), `CT_PIN_SPARE};
			pin_oe_d = `CT_PIN_OE_ROUTED;
		end else begin
			pin_out_d = dio_out_i;
			pin_oe_d = dio_oe_i;
		end
	end

	// every output leaves straight from a flop
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= `CT_BYTE_RST;
			pin_out_o <= `CT_PIN_RST;
			pin_oe_o <= `CT_PIN_RST;
			dio_in_o <= `CT_PIN_RST;
			counter_zero_out_o <= 1'b0;
			counter_zero_value_o <= `CT_C0_RST;
			counter_one_value_o <= `CT_C1_RST;
		end else begin
			reg_rdata_o <= rdata_d;
			pin_out_o <= pin_out_d;
			pin_oe_o <= pin_oe_d;
			dio_in_o <= dio_in_d;
			counter_zero_out_o <= c0_out_d;
			counter_zero_value_o <= count0_q;
			counter_one_value_o <= count1_q;
		end
	end

endmodule
`default_nettype wire

/* shared/counter_timer_consts.vh */
// constants for the dual down-counter timer block
`ifndef COUNTER_TIMER_CONSTS_VH
`define COUNTER_TIMER_CONSTS_VH

// register offsets (byte addresses on the 4-bit register port)
`define CT_ADDR_W 4
`define CT_OFS_LOW 4'hc
`define CT_OFS_MID 4'hd
`define CT_OFS_HIGH 4'he
`define CT_OFS_CMD 4'hf

// counter widths
`define CT_C0_W 24
`define CT_C1_W 16

// command bit positions
`define CT_CMD_SEL 7
`define CT_CMD_LATCH 6
`define CT_CMD_GATE_OFF 5
`define CT_CMD_GATE_ON 4
`define CT_CMD_COUNT_OFF 3
`define CT_CMD_COUNT_ON 2
`define CT_CMD_LOAD 1
`define CT_CMD_ZERO 0

// decoded operation codes
`define CT_OP_NONE 3'h0
`define CT_OP_LATCH 3'h1
`define CT_OP_GATE_OFF 3'h2
`define CT_OP_GATE_ON 3'h3
`define CT_OP_COUNT_OFF 3'h4
`define CT_OP_COUNT_ON 3'h5
`define CT_OP_LOAD 3'h6
`define CT_OP_ZERO 3'h7

// identity fields, values arbitrary
`define CT_BOARD_ID 4'h3
`define CT_LOGIC_REV 4'h1

// reset values
`define CT_BYTE_RST 8'h00
`define CT_C0_RST 24'h000000
`define CT_C1_RST 16'h0000

// count step and pin drive levels
`define CT_C0_STEP 24'h000001
`define CT_C1_STEP 16'h0001
`define CT_PIN_RST 4'h0
`define CT_PIN_OE_ROUTED 4'h8
`define CT_PIN_SPARE 3'h0
`define CT_DIO_SPARE 1'b0

`endif
